// [design/ctg_timing_gen.sv]
module ctg_timing_gen (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic HRESP,
	output logic [31:0] HRDATA,
	input wire logic LINE_SYNC_INPUT,
	output logic [12:0] LOW_SPEED_LINE_SIGNAL,
	output logic [1:0] PHASE_CLOCK_A,
	output logic [1:0] PHASE_CLOCK_B,
	output logic [1:0] PHASE_CLOCK_C,
	output logic CHARGE_RESET_PULSE,
	output logic CLAMP_PULSE_OUT
);

	// ********************************
	// Register storage
	// ********************************
	ctg_pkg::ctg_ctrl_t ctrl;
	logic [15:0] line_len;
	logic [12:0] pol_ls;
	logic [4:0] pol_hs;
	logic [12:0] inv_ls [ctg_pkg::NUM_LINES];
	logic [4:0] inv_hs [ctg_pkg::NUM_LINES];
	logic [5:0] hs_on [ctg_pkg::NUM_HS];
	logic [5:0] hs_off [ctg_pkg::NUM_HS];
	logic [15:0] ls_on [ctg_pkg::NUM_LS];
	logic [15:0] ls_off [ctg_pkg::NUM_LS];
	logic [7:0] st_len [ctg_pkg::NUM_STATES];
	logic [12:0] st_lvl [ctg_pkg::NUM_STATES];

	// ********************************
	// AHB-Lite slave
	// ********************************
	logic wr_pend;
	logic [9:0] wr_idx;
	logic stall_q;
	logic stall;
	logic wr_go;
	logic addr_ok;
	logic rd_take;
	logic [9:0] rd_idx;
	logic [9:0] wr_off;
	logic [9:0] rd_off;
	logic [31:0] next_rdata;
	logic [31:0] status;

	assign HRESP = 1'b0;
	assign addr_ok = HADDR[31:12] == 20'h00000;
	assign rd_idx = HADDR[11:2];
	// A read right behind a write waits one cycle so it sees the new value
	assign stall = wr_pend && !stall_q && HSEL && HTRANS[1] && !HWRITE;
	assign HREADYOUT = !stall;
	assign wr_go = wr_pend && !stall_q;
	assign rd_take = HREADY && HSEL && HTRANS[1] && !HWRITE;

	// Address phase capture; only word accesses are expected
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			wr_pend <= 1'b0;
			wr_idx <= 10'h000;
			stall_q <= 1'b0;
		end else begin
			stall_q <= stall;
			if (HREADY) begin
				wr_pend <= HSEL && HTRANS[1] && HWRITE && addr_ok;
				wr_idx <= HADDR[11:2];
			end
		end
	end

	// Single-word registers
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ctrl <= ctg_pkg::CTRL_RESET;
			line_len <= ctg_pkg::LINE_LEN_RESET;
			pol_ls <= 13'h0000;
			pol_hs <= 5'h00;
		end else if (wr_go) begin
			if (wr_idx == ctg_pkg::IDX_CTRL) begin
				ctrl <= {HWDATA[14:12], HWDATA[9:8], HWDATA[5:0]};
			end
			if (wr_idx == ctg_pkg::IDX_LINE) begin
				line_len <= HWDATA[15:0];
			end
			if (wr_idx == ctg_pkg::IDX_POL) begin
				pol_ls <= HWDATA[12:0];
				pol_hs <= HWDATA[ctg_pkg::POL_HS_LSB +: 5];
			end
		end
	end

	assign wr_off = wr_idx - ctg_pkg::IDX_INV;

	// Per-line inversion words
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			for (int i = 0; i < ctg_pkg::NUM_LINES; i++) begin
				inv_ls[i] <= 13'h0000;
				inv_hs[i] <= 5'h00;
			end
		end else if (wr_go && wr_idx >= ctg_pkg::IDX_INV && wr_idx < ctg_pkg::IDX_INV_END) begin
			inv_ls[wr_off[1:0]] <= HWDATA[12:0];
			inv_hs[wr_off[1:0]] <= HWDATA[ctg_pkg::POL_HS_LSB +: 5];
		end
	end

	// High-speed edge positions
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			for (int i = 0; i < ctg_pkg::NUM_HS; i++) begin
				hs_on[i] <= 6'h00;
				hs_off[i] <= 6'h00;
			end
		end else if (wr_go && wr_idx >= ctg_pkg::IDX_HS && wr_idx < ctg_pkg::IDX_HS_END) begin
			hs_on[3'(wr_idx - ctg_pkg::IDX_HS)] <= HWDATA[5:0];
			hs_off[3'(wr_idx - ctg_pkg::IDX_HS)] <= HWDATA[ctg_pkg::HS_OFF_LSB +: 6];
		end
	end

	// Low-speed ON/OFF points
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			for (int i = 0; i < ctg_pkg::NUM_LS; i++) begin
				ls_on[i] <= 16'h0000;
				ls_off[i] <= 16'h0000;
			end
		end else if (wr_go && wr_idx >= ctg_pkg::IDX_LS && wr_idx < ctg_pkg::IDX_LS_END) begin
			ls_on[4'(wr_idx - ctg_pkg::IDX_LS)] <= HWDATA[15:0];
			ls_off[4'(wr_idx - ctg_pkg::IDX_LS)] <= HWDATA[ctg_pkg::LS_OFF_LSB +: 16];
		end
	end

	// Gate state table; zero length is the reset value, so idle is safe
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			for (int i = 0; i < ctg_pkg::NUM_STATES; i++) begin
				st_len[i] <= 8'h00;
				st_lvl[i] <= 13'h0000;
			end
		end else if (wr_go && wr_idx >= ctg_pkg::IDX_ST && wr_idx < ctg_pkg::IDX_ST_END) begin
			st_len[5'(wr_idx - ctg_pkg::IDX_ST)] <= HWDATA[7:0];
			st_lvl[5'(wr_idx - ctg_pkg::IDX_ST)] <= HWDATA[ctg_pkg::ST_LVL_LSB +: 13];
		end
	end

	assign rd_off = rd_idx - ctg_pkg::IDX_INV;

	// Read mux; unmapped words read as zero
	always_comb begin
		next_rdata = 32'h0000_0000;
		if (!addr_ok) begin
			next_rdata = 32'h0000_0000;
		end else if (rd_idx == ctg_pkg::IDX_CTRL) begin
			next_rdata = {17'h00000, ctrl.smul, 2'b00, ctrl.pmul, 2'b00, ctrl.nint,
				ctrl.half, ctrl.three_ch, ctrl.master, ctrl.lock};
		end else if (rd_idx == ctg_pkg::IDX_LINE) begin
			next_rdata = {16'h0000, line_len};
		end else if (rd_idx == ctg_pkg::IDX_POL) begin
			next_rdata = {11'h000, pol_hs, 3'h0, pol_ls};
		end else if (rd_idx == ctg_pkg::IDX_STAT) begin
			next_rdata = status;
		end else if (rd_idx >= ctg_pkg::IDX_INV && rd_idx < ctg_pkg::IDX_INV_END) begin
			next_rdata = {11'h000, inv_hs[rd_off[1:0]], 3'h0, inv_ls[rd_off[1:0]]};
		end else if (rd_idx >= ctg_pkg::IDX_HS && rd_idx < ctg_pkg::IDX_HS_END) begin
			next_rdata = {18'h00000, hs_off[3'(rd_idx - ctg_pkg::IDX_HS)], 2'b00,
				hs_on[3'(rd_idx - ctg_pkg::IDX_HS)]};
		end else if (rd_idx >= ctg_pkg::IDX_LS && rd_idx < ctg_pkg::IDX_LS_END) begin
			next_rdata = {ls_off[4'(rd_idx - ctg_pkg::IDX_LS)],
				ls_on[4'(rd_idx - ctg_pkg::IDX_LS)]};
		end else if (rd_idx >= ctg_pkg::IDX_ST && rd_idx < ctg_pkg::IDX_ST_END) begin
			next_rdata = {3'h0, st_lvl[5'(rd_idx - ctg_pkg::IDX_ST)], 8'h00,
				st_len[5'(rd_idx - ctg_pkg::IDX_ST)]};
		end
	end

	// Read data is latched in the address phase and stands in the data phase
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			HRDATA <= 32'h0000_0000;
		end else if (rd_take) begin
			HRDATA <= next_rdata;
		end
	end

	// ********************************
	// Pixel divider and line sync
	// ********************************
	logic [5:0] sub;
	logic par;
	logic pix_en;
	logic sync1;
	logic sync2;
	logic sync3;
	logic sync_seen;

	// At or past the last position, so a mode switch mid-pixel never runs the count to wrap
	assign pix_en = sub >= (ctrl.three_ch ? ctg_pkg::PIX_LAST_3CH : ctg_pkg::PIX_LAST_12CH);

	// Edge-position counter; one pixel enable per 42 or 28 clocks
	always_ff @(posedge CLK) begin
		if (!RST_N || pix_en) begin
			sub <= 6'h00;
		end else begin
			sub <= sub + 6'h01;
		end
	end

	// Pixel parity drives the half-rate clocks
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			par <= 1'b0;
		end else if (pix_en) begin
			par <= !par;
		end
	end

	// Sync pin crosses in through two flops before the edge detector
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sync1 <= 1'b0;
			sync2 <= 1'b0;
			sync3 <= 1'b0;
		end else begin
			sync1 <= LINE_SYNC_INPUT;
			sync2 <= sync1;
			sync3 <= sync2;
		end
	end

	// ********************************
	// Line sequencer
	// ********************************
	ctg_pkg::ctg_seq_t seq;
	logic [4:0] st;
	logic [14:0] cnt;
	logic [17:0] pc;
	logic [1:0] line;
	logic [1:0] inv_sel;
	logic [1:0] line_nx;
	logic [2:0] smul_eff;
	logic [14:0] st_last_cnt;
	logic [17:0] line_scaled;
	logic [4:0] ent_first;
	logic ent_zero;
	logic [4:0] st_nx;
	logic st_end;
	logic line_go;
	logic start_ok;
	logic line_end;

	assign line_nx = (line == ctrl.nint) ? 2'b00 : line + 2'b01;
	assign smul_eff = (ctrl.smul > ctg_pkg::SMUL_MAX) ? ctg_pkg::SMUL_MAX : ctrl.smul;
	assign st_last_cnt = ({7'h00, st_len[st]} << smul_eff) - 15'h0001;
	assign line_scaled = {2'b00, line_len} << ctrl.pmul;
	assign ent_first = ctg_pkg::PART_FIRST[ctrl.nint][line];
	assign ent_zero = st_len[ent_first] == 8'h00;
	assign st_nx = st + 5'h01;
	// Interval ends at its last state or where the next state has zero length
	assign st_end = (st == ctg_pkg::PART_LAST[ctrl.nint][line]) || (st_len[st_nx] == 8'h00);
	assign line_end = (pc + 18'h00001) >= line_scaled;
	assign start_ok = ctrl.master ? ctrl.lock : sync_seen;
	assign line_go = pix_en && start_ok && (seq == ctg_pkg::SEQ_IDLE
		|| (seq == ctg_pkg::SEQ_PIXEL && line_end));

	// Slave start request; a new sync edge wins over its consumption
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sync_seen <= 1'b0;
		end else if (sync2 && !sync3) begin
			sync_seen <= !ctrl.master;
		end else if (line_go || ctrl.master) begin
			sync_seen <= 1'b0;
		end
	end

	// Main sequence: idle, gate states, pixel portion, all on pixel enables
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			seq <= ctg_pkg::SEQ_IDLE;
			st <= 5'h00;
			cnt <= 15'h0000;
			pc <= 18'h00000;
			line <= 2'b00;
			inv_sel <= 2'b00;
		end else if (line_go) begin
			cnt <= 15'h0000;
			pc <= 18'h00000;
			st <= ent_first;
			if (ent_zero) begin
				seq <= ctg_pkg::SEQ_PIXEL;
				inv_sel <= line;
				line <= line_nx;
			end else begin
				seq <= ctg_pkg::SEQ_GATE;
			end
		end else if (pix_en && seq == ctg_pkg::SEQ_GATE) begin
			if (cnt != st_last_cnt) begin
				cnt <= cnt + 15'h0001;
			end else if (st_end) begin
				seq <= ctg_pkg::SEQ_PIXEL;
				pc <= 18'h00000;
				inv_sel <= line;
				line <= line_nx;
			end else begin
				st <= st_nx;
				cnt <= 15'h0000;
			end
		end else if (pix_en && seq == ctg_pkg::SEQ_PIXEL) begin
			if (!line_end) begin
				pc <= pc + 18'h00001;
			end else begin
				seq <= ctg_pkg::SEQ_IDLE; // Lock dropped or no sync pending
				line <= 2'b00;
			end
		end
	end

	assign status = {pc[15:0], 7'h00, st, line, seq == ctg_pkg::SEQ_GATE,
		seq != ctg_pkg::SEQ_IDLE};

	// ********************************
	// Signal generators and pins
	// ********************************
	logic [12:0] ls_lvl;
	logic [4:0] hs_lvl;
	logic pix_run;

	assign pix_run = seq == ctg_pkg::SEQ_PIXEL;

	// Slow ON/OFF line signals during the pixel portion
	for (genvar g = 0; g < ctg_pkg::NUM_LS; g++) begin : g_ls
		ctg_onoff u_onoff (
			.clk(CLK),
			.rst_n(RST_N),
			.pc(pc),
			.pm(ctrl.pmul),
			.on_pt(ls_on[g]),
			.off_pt(ls_off[g]),
			.lvl(ls_lvl[g])
		);
	end

	// Phase A, B, C, charge reset and clamp clocks
	for (genvar g = 0; g < ctg_pkg::NUM_HS; g++) begin : g_hs
		ctg_hs_gen u_hs (
			.clk(CLK),
			.rst_n(RST_N),
			.run(pix_run),
			.sub(sub),
			.par(par),
			.half(ctrl.half),
			.on_pos(hs_on[g]),
			.off_pos(hs_off[g]),
			.lvl(hs_lvl[g])
		);
	end

	// Pins are registered so mode changes never glitch; idle shows polarity only
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			LOW_SPEED_LINE_SIGNAL <= 13'h0000;
		end else if (seq == ctg_pkg::SEQ_GATE) begin
			LOW_SPEED_LINE_SIGNAL <= pol_ls ^ st_lvl[st];
		end else if (pix_run) begin
			LOW_SPEED_LINE_SIGNAL <= pol_ls ^ ls_lvl ^ inv_ls[inv_sel];
		end else begin
			LOW_SPEED_LINE_SIGNAL <= pol_ls;
		end
	end

	// High-speed pins; each phase pair is a complementary couple sharing one bit
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			PHASE_CLOCK_A <= 2'b10;
			PHASE_CLOCK_B <= 2'b10;
			PHASE_CLOCK_C <= 2'b10;
			CHARGE_RESET_PULSE <= 1'b0;
			CLAMP_PULSE_OUT <= 1'b0;
		end else begin
			PHASE_CLOCK_A <= {~(pol_hs[0] ^ (pix_run & (hs_lvl[0] ^ inv_hs[inv_sel][0]))),
				pol_hs[0] ^ (pix_run & (hs_lvl[0] ^ inv_hs[inv_sel][0]))};
			PHASE_CLOCK_B <= {~(pol_hs[1] ^ (pix_run & (hs_lvl[1] ^ inv_hs[inv_sel][1]))),
				pol_hs[1] ^ (pix_run & (hs_lvl[1] ^ inv_hs[inv_sel][1]))};
			PHASE_CLOCK_C <= {~(pol_hs[2] ^ (pix_run & (hs_lvl[2] ^ inv_hs[inv_sel][2]))),
				pol_hs[2] ^ (pix_run & (hs_lvl[2] ^ inv_hs[inv_sel][2]))};
			CHARGE_RESET_PULSE <= pol_hs[3] ^ (pix_run & (hs_lvl[3] ^ inv_hs[inv_sel][3]));
			CLAMP_PULSE_OUT <= pol_hs[4] ^ (pix_run & (hs_lvl[4] ^ inv_hs[inv_sel][4]));
		end
	end

	// Control marks for the data stream live in the output formatter, not here.

endmodule : ctg_timing_gen

// [design/ctg_pkg.sv]
package ctg_pkg;

	// ********************************
	// Sizes
	// ********************************
	localparam int NUM_STATES = 31;
	localparam int NUM_LS = 13;
	localparam int NUM_HS = 5;
	localparam int NUM_LINES = 4;

	// ********************************
	// Pixel period in edge positions (last tick index)
	// ********************************
	localparam logic [5:0] PIX_LAST_3CH = 6'h29; // 42 positions
	localparam logic [5:0] PIX_LAST_12CH = 6'h1B; // 28 positions

	// ********************************
	// Register word indices (byte address = 4 x index)
	// ********************************
	localparam logic [9:0] IDX_CTRL = 10'h000;
	localparam logic [9:0] IDX_LINE = 10'h001;
	localparam logic [9:0] IDX_POL = 10'h002;
	localparam logic [9:0] IDX_STAT = 10'h003;
	localparam logic [9:0] IDX_INV = 10'h010;
	localparam logic [9:0] IDX_INV_END = 10'h014;
	localparam logic [9:0] IDX_HS = 10'h020;
	localparam logic [9:0] IDX_HS_END = 10'h025;
	localparam logic [9:0] IDX_LS = 10'h040;
	localparam logic [9:0] IDX_LS_END = 10'h04D;
	localparam logic [9:0] IDX_ST = 10'h080;
	localparam logic [9:0] IDX_ST_END = 10'h09F;

	// ********************************
	// Field positions and reset values
	// ********************************
	localparam int POL_HS_LSB = 16;
	localparam int ST_LVL_LSB = 16;
	localparam int LS_OFF_LSB = 16;
	localparam int HS_OFF_LSB = 8;
	localparam logic [15:0] LINE_LEN_RESET = 16'h0100;
	localparam logic [2:0] SMUL_MAX = 3'h4;

	// Control word: bit 1 is master select, bit 0 the scan lock
	typedef struct packed {
		logic [2:0] smul; // [14:12] state length shift, 0 = 1x
		logic [1:0] pmul; // [9:8] pixel multiplier shift
		logic [1:0] nint; // [5:4] interval count minus one
		logic half; // [3] half-rate high-speed clocks
		logic three_ch; // [2] 42 edge positions per pixel
		logic master; // [1]
		logic lock; // [0]
	} ctg_ctrl_t;
	localparam ctg_ctrl_t CTRL_RESET = '0;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_GATE = 2'b01,
		SEQ_PIXEL = 2'b11
	} ctg_seq_t;

	// First and last state of each interval, by interval count and line
	localparam logic [4:0] PART_FIRST [4][4] = '{
		'{5'h00, 5'h00, 5'h00, 5'h00},
		'{5'h00, 5'h0F, 5'h00, 5'h00},
		'{5'h00, 5'h0A, 5'h14, 5'h00},
		'{5'h00, 5'h07, 5'h0F, 5'h17}};
	localparam logic [4:0] PART_LAST [4][4] = '{
		'{5'h1E, 5'h1E, 5'h1E, 5'h1E},
		'{5'h0E, 5'h1E, 5'h1E, 5'h1E},
		'{5'h09, 5'h13, 5'h1E, 5'h1E},
		'{5'h06, 5'h0E, 5'h16, 5'h1E}};

endpackage : ctg_pkg

// [design/ctg_hs_gen.sv]
// One high-speed pixel clock: set at the ON position, cleared at OFF
module ctg_hs_gen (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic [5:0] sub,
	input wire logic par,
	input wire logic half,
	input wire logic [5:0] on_pos,
	input wire logic [5:0] off_pos,
	output logic lvl
);

	// Half rate: rise only on even pixels, fall only on odd ones
	always_ff @(posedge clk) begin
		if (!rst_n || !run) begin
			lvl <= 1'b0; // Stopped clocks rest low before polarity
		end else if (sub == on_pos && (!half || !par)) begin
			lvl <= 1'b1;
		end else if (sub == off_pos && (!half || par)) begin
			lvl <= 1'b0;
		end
	end

endmodule : ctg_hs_gen

// [design/ctg_onoff.sv]
// One low-speed line signal: level from ON/OFF pixel numbers
module ctg_onoff (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [17:0] pc,
	input wire logic [1:0] pm,
	input wire logic [15:0] on_pt,
	input wire logic [15:0] off_pt,
	output logic lvl
);

	logic [17:0] on_s;
	logic [17:0] off_s;

	// Both points share the line's pixel multiplier
	assign on_s = {2'b00, on_pt} << pm;
	assign off_s = {2'b00, off_pt} << pm;

	// Order of the points picks normally-low, normally-high or constant
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lvl <= 1'b0;
		end else if (on_s < off_s) begin
			lvl <= (pc >= on_s) && (pc < off_s);
		end else if (on_s > off_s) begin
			lvl <= !((pc >= off_s) && (pc < on_s));
		end else begin
			lvl <= 1'b0;
		end
	end

endmodule : ctg_onoff

// [verification/ctg_timing_gen_assertions.sv]
// ********************************
// Port checker for the timing generator
// ********************************
module ctg_timing_gen_chk (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic [31:0] HRDATA,
	input wire logic LINE_SYNC_INPUT,
	input wire logic [12:0] LOW_SPEED_LINE_SIGNAL,
	input wire logic [1:0] PHASE_CLOCK_A,
	input wire logic [1:0] PHASE_CLOCK_B,
	input wire logic [1:0] PHASE_CLOCK_C,
	input wire logic CHARGE_RESET_PULSE,
	input wire logic CLAMP_PULSE_OUT
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic rd_take;
	logic prev_a;
	logic [5:0] gap_a;
	// Read accepted by the slave in this cycle
	assign rd_take = HSEL && HTRANS[1] && !HWRITE && HREADY;
	// Cycles since phase clock A last rose; saturates so long gate spans stay legal
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			prev_a <= 1'b0;
			gap_a <= 6'h3F;
		end else begin
			prev_a <= PHASE_CLOCK_A[0];
			if (PHASE_CLOCK_A[0] && !prev_a) begin
				gap_a <= 6'h00;
			end else if (gap_a != 6'h3F) begin
				gap_a <= gap_a + 6'h01;
			end
		end
	end
	sequence s_unmapped_read;
		rd_take && HADDR[31:12] != 20'h00000;
	endsequence
	AST_PHASE_PAIR: assert property (PHASE_CLOCK_A[1] != PHASE_CLOCK_A[0]
		&& PHASE_CLOCK_B[1] != PHASE_CLOCK_B[0] && PHASE_CLOCK_C[1] != PHASE_CLOCK_C[0])
		else $error("phase clock pair not complementary");
	AST_PHASE_SPACING: assert property ((PHASE_CLOCK_A[0] && !prev_a) |-> gap_a >= 6'h1B)
		else $error("phase clock A rose twice within one pixel");
	AST_LS_GLITCH_FREE: assert property ($changed(LOW_SPEED_LINE_SIGNAL[0]) |=>
		$stable(LOW_SPEED_LINE_SIGNAL[0])[*3])
		else $error("line signal 0 glitched");
	AST_OKAY_ONLY: assert property (HRESP == 1'b0)
		else $error("bus response not okay");
	AST_WAIT_ONE: assert property (!HREADYOUT |=> HREADYOUT)
		else $error("wait state longer than one cycle");
	AST_RDATA_HOLDS: assert property ($changed(HRDATA) |-> $past(rd_take))
		else $error("read data changed without a read");
	AST_UNMAPPED_ZERO: assert property (s_unmapped_read |=> HRDATA == 32'h00000000)
		else $error("unmapped read returned data");
	AST_RESET_STATE: assert property ($rose(RST_N) |-> LOW_SPEED_LINE_SIGNAL == 13'h0000
		&& PHASE_CLOCK_A == 2'b10 && PHASE_CLOCK_B == 2'b10 && PHASE_CLOCK_C == 2'b10
		&& !CHARGE_RESET_PULSE && !CLAMP_PULSE_OUT && HREADYOUT)
		else $error("outputs not at rest after reset");
endmodule : ctg_timing_gen_chk

bind ctg_timing_gen ctg_timing_gen_chk u_chk (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL),
	.HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
	.HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .HRDATA(HRDATA),
	.LINE_SYNC_INPUT(LINE_SYNC_INPUT), .LOW_SPEED_LINE_SIGNAL(LOW_SPEED_LINE_SIGNAL),
	.PHASE_CLOCK_A(PHASE_CLOCK_A), .PHASE_CLOCK_B(PHASE_CLOCK_B), .PHASE_CLOCK_C(PHASE_CLOCK_C),
	.CHARGE_RESET_PULSE(CHARGE_RESET_PULSE), .CLAMP_PULSE_OUT(CLAMP_PULSE_OUT));

// [verification/ctg_sensor_model.sv]
// ********************************
// Sensor side: counts shifted pixels, makes slave line syncs
// ********************************
module ctg_sensor_model #(
	parameter int SYNC_SPACING = 400
) (
	input wire logic clk,
	input wire logic sync_en,
	input wire logic [1:0] phase_a,
	output logic line_sync,
	output int pixels
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	logic prev = 1'b0;
	initial begin
		line_sync = 1'b0;
		pixels = 0;
	end
	// Four clocks high so the two-flop synchroniser cannot miss a pulse
	always @(posedge clk) begin
		cnt <= sync_en ? cnt + 1 : 0;
		line_sync <= sync_en && (cnt % SYNC_SPACING) < 4;
	end
	// Each rise of phase clock A shifts one pixel out
	always @(posedge clk) begin
		prev <= phase_a[0];
		pixels <= pixels + int'(phase_a[0] && !prev);
	end
endmodule : ctg_sensor_model

// [verification/ctg_timing_gen_tb.sv]
module ctg_timing_gen_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h00000000;
	logic sync_en = 1'b0;
	logic hready;
	logic [31:0] hrdata;
	logic sync;
	logic [12:0] ls;
	logic [1:0] pa;
	logic crp;
	int pixels;
	int n_errors = 0;
	int checked = 0;
	int exp_q[$];
	int first_st [4][4] = '{'{0, 0, 0, 0}, '{0, 15, 0, 0}, '{0, 10, 20, 0}, '{0, 7, 15, 23}};

	always #25 clk = ~clk;

	ctg_timing_gen u_ctg_timing_gen (.CLK(clk), .RST_N(rst_n), .HSEL(1'b1), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hready),
		.HREADYOUT(hready), .HRESP(), .HRDATA(hrdata), .LINE_SYNC_INPUT(sync),
		.LOW_SPEED_LINE_SIGNAL(ls), .PHASE_CLOCK_A(pa), .PHASE_CLOCK_B(), .PHASE_CLOCK_C(),
		.CHARGE_RESET_PULSE(crp), .CLAMP_PULSE_OUT());
	ctg_sensor_model u_ctg_sensor_model (.clk(clk), .sync_en(sync_en), .phase_a(pa),
		.line_sync(sync), .pixels(pixels));

	task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			n_errors++;
			$display("unexpected %s: expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// One single transfer; hready is looked at just before each rising edge
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		logic ok;
		@(posedge clk);
		htrans <= 2'b10;
		haddr <= a;
		hwrite <= w;
		do begin
			@(negedge clk);
			ok = hready;
			@(posedge clk);
		end while (!ok);
		htrans <= 2'b00;
		hwdata <= d;
		do begin
			@(negedge clk);
			ok = hready;
			r = hrdata;
			@(posedge clk);
		end while (!ok);
	endtask : bus

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask : wr

	task rd(input logic [31:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h00000000, r);
	endtask : rd

	// Waits for the line signals to leave base, then times the new value
	task wait_ne(input logic [12:0] base, output logic [12:0] v, output int hold);
		int t;
		t = 0;
		do begin
			@(negedge clk);
			t++;
		end while (ls === base && t < 20000);
		v = ls;
		hold = 0;
		do begin
			@(negedge clk);
			hold++;
		end while (ls === v && hold < 20000);
	endtask : wait_ne

	// Clearing lock lets the current line finish before the generator rests
	task stop;
		logic [31:0] r;
		int t;
		wr(32'h00000000, 32'h00000000);
		t = 0;
		do begin
			rd(32'h0000000C, r);
			t++;
		end while (r[0] !== 1'b0 && t < 400);
		chk("running", 32'h00000000, {31'h0, r[0]});
	endtask : stop

	function logic [31:0] ctl(input int sm, input int pm, input int ni, input int c3);
		return 32'((sm << 12) | (pm << 8) | (ni << 4) | (c3 << 2) | 3);
	endfunction : ctl

	task complete_run;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

	// Watchdog well beyond the expected run of some 15000 cycles
	initial begin
		repeat (60000) @(posedge clk);
		n_errors++;
		complete_run;
	end

	initial begin
		logic [31:0] r;
		logic [31:0] q;
		logic [12:0] v;
		logic [12:0] p;
		logic [12:0] iv;
		int h;
		int k;
		int n;
		int j;
		int len;
		int pix0;
		void'($urandom(32'h1280));
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// Rest values and refused places
		rd(32'h00000000, r);
		chk("ctrl", 32'h00000000, r);
		rd(32'h00000004, r);
		chk("line_len", 32'h00000100, r);
		chk("rest_ls", 32'h00000000, 32'(ls));
		chk("rest_reset_pulse", 32'h00000000, 32'(crp));
		wr(32'h00001000, 32'hFFFFFFFF);
		rd(32'h00001000, r);
		chk("unmapped", 32'h00000000, r);
		rd(32'h0000027C, r);
		chk("state_31", 32'h00000000, r);
		r = $urandom;
		wr(32'h00000200, r);
		rd(32'h00000200, q);
		chk("state_word", r & 32'h1FFF00FF, q);
		for (k = 0; k < 31; k++) wr(32'h00000200 + 32'(4 * k), 32'h00000000);
		wr(32'h00000004, 32'h00000004);
		wr(32'h00000080, 32'h00000A02);
		// State length under multipliers 0 to 4, a 255 boundary and 42 positions
		for (k = 0; k < 7; k++) begin
			len = (k == 5) ? 255 : 1 + $urandom % 3;
			wr(32'h00000200, 32'h10000000 | 32'(len));
			wr(32'h00000000, ctl(k < 5 ? k : 0, 0, 0, int'(k == 6)));
			wait_ne(13'h0000, v, h);
			chk("gate_level", 32'h00001000, 32'(v));
			len = (len << (k < 5 ? k : 0)) * (k == 6 ? 42 : 28);
			chk("gate_cycles", 32'(len), 32'(h));
			stop;
		end
		// Interval sequences over one to four partitions, wrapping to the first
		for (n = 0; n < 4; n++) begin
			for (j = 0; j <= n; j++) wr(32'h00000200 + 32'(4 * first_st[n][j]), 32'((j + 1) << 16 | 1));
			wr(32'h00000000, ctl(0, 0, n, 0));
			for (j = 0; j < n + 2; j++) exp_q.push_back(j % (n + 1) + 1);
			for (j = 0; j < n + 2; j++) begin
				wait_ne(13'h0000, v, h);
				chk("interval", 32'(exp_q.pop_front()), 32'(v));
			end
			stop;
		end
		// ON/OFF pulse on line signal 0 under pixel multipliers 0 to 2, last pass at half rate
		wr(32'h00000100, 32'h00030001);
		for (k = 0; k < 4; k++) begin
			wr(32'h00000000, ctl(0, k % 3, 0, 0) | (32'(k == 3) << 3));
			wait_ne(13'h0000, v, h);
			pix0 = pixels;
			wait_ne(13'h0000, v, h);
			chk("pulse_level", 32'h00000001, 32'(v));
			chk("pulse_cycles", 32'((2 << k % 3) * 28), 32'(h));
			wait_ne(13'h0000, v, h);
			chk("line_pixels", 32'(4 << k % 3 >> k / 3), 32'(pixels - pix0));
			stop;
		end
		// Polarity at rest, then inversion of the pixel portion
		p = 13'($urandom);
		iv = 13'($urandom) | 13'h0002;
		wr(32'h00000008, 32'(p) | 32'h00080000);
		repeat (2) @(negedge clk);
		chk("rest_polarity", 32'(p), 32'(ls));
		chk("rest_reset_pulse", 32'h00000001, 32'(crp));
		wr(32'h00000040, 32'(iv));
		wr(32'h00000000, ctl(0, 0, 0, 0));
		wait_ne(p, v, h);
		chk("gate_polarity", 32'(p ^ 13'h0001), 32'(v));
		chk("pixel_inverted", 32'(p ^ iv), 32'(ls));
		stop;
		// Slave mode: each sync pulse from the sensor side starts a line
		sync_en <= 1'b1;
		wait_ne(p, v, h);
		chk("slave_line", 32'(p ^ 13'h0001), 32'(v));
		@(posedge clk);
		sync_en <= 1'b0;
		complete_run;
	end
endmodule : ctg_timing_gen_tb
